// ---- spar_pkg.sv ----
// spar_pkg: register map, field layouts, timing counts and types of the
// serial port with address recognition.
// assumes: CLOCK_I is the oscillator itself, 20 MHz.
package spar_pkg;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_SCTL  = 8'h10;  // serial control register
  localparam logic [7:0] IDX_DATA  = 8'h11;  // tx write, rx read
  localparam logic [7:0] IDX_PCTL  = 8'h12;  // power control register
  localparam logic [7:0] IDX_BAUD  = 8'h13;  // variable rate reload
  localparam logic [7:0] IDX_ISTAT = 8'h14;  // sticky event status
  localparam logic [7:0] IDX_IMASK = 8'h15;  // event mask
  localparam logic [7:0] IDX_SLADR = 8'hA9;  // slave address
  localparam logic [7:0] IDX_SLMSK = 8'hB9;  // slave address mask

  // event status bit positions
  localparam int IRQ_TX   = 0;  // transmit done
  localparam int IRQ_RX   = 1;  // receive done
  localparam int IRQ_FERR = 2;  // framing error
  localparam int IRQ_W    = 3;

  // reset values
  localparam logic [7:0]       SCTL_RST  = 8'h00;
  localparam logic [7:0]       SLADR_RST = 8'h00;
  localparam logic [7:0]       SLMSK_RST = 8'h00;
  localparam logic [7:0]       BAUD_RST  = 8'h00;
  localparam logic [2:0]       PCTL_RST  = 3'h0;
  localparam logic [IRQ_W-1:0] IMASK_RST = 3'h0;

  // timing: oscillator periods per shift clock in standard speed
  localparam int         OSC_HZ       = 20_000_000;
  localparam int         SHIFT_T_STD  = 12;
  localparam int         OSC_PER_BASE = 2;  // standard speed halves
  localparam int         MC_BASE      = SHIFT_T_STD / OSC_PER_BASE;
  localparam logic [2:0] MC_LAST      = 3'(MC_BASE - 1);
  localparam logic [2:0] M0_RISE      = 3'(MC_BASE / 2);
  localparam logic [3:0] OVS_MID      = 4'h7;  // half of 16 ticks
  localparam logic [3:0] OVS_LAST     = 4'hF;  // 16 ticks per bit
  localparam logic [3:0] LAST_BIT8    = 4'h7;
  localparam logic [3:0] LAST_BIT9    = 4'h8;

  // port modes from the two mode select bits
  typedef enum logic [1:0] {
    MODE_SHIFT  = 2'b00,
    MODE_UART8  = 2'b01,
    MODE_UART9F = 2'b10,
    MODE_UART9V = 2'b11
  } spar_mode_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } spar_txst_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } spar_rxst_t;

  // serial control register layout, bit 7 first
  typedef struct packed {
    logic mode_select_hi;
    logic mode_select_lo;
    logic multiproc_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } spar_sctl_t;

  // power control register layout, bits 2..0
  typedef struct packed {
    logic baud_double;
    logic double_speed_select;
    logic framing_check_select;
  } spar_pctl_t;

  // timing events from the divider
  typedef struct packed {
    logic m0_lo;    // shift clock low phase
    logic m0_rise;  // shift clock rising edge
    logic m0_end;   // end of a shift bit
    logic ovs_fix;  // 16x tick, fixed rate
    logic ovs_var;  // 16x tick, variable rate
  } spar_ticks_t;

endpackage

// ---- spar_baud.sv ----
// spar_baud: divides the oscillator into shift and 16x sample ticks.
// assumes: same clock and reset as the serial port top.
module spar_baud (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  input  wire logic               ds_i,
  input  wire logic               baud_dbl_i,
  input  wire logic [7:0]         reload_i,
  output spar_pkg::spar_ticks_t   ticks_o
);
  import spar_pkg::*;

  logic       div2_r, div2_nxt;  // oscillator divided by two
  logic       ds_r, ds_nxt;      // double speed, glitch free copy
  logic [2:0] mc_r, mc_nxt;      // base ticks within a shift bit
  logic       half_r, half_nxt;  // halves the fixed rate
  logic [7:0] var_r, var_nxt;    // variable rate divider
  logic       base;              // one base tick

  // next values of the divider chain
  always_comb begin
    div2_nxt = ~div2_r;
    // only taken as the divided clock rises
    ds_nxt   = (~div2_r) ? ds_i : ds_r;
    // double speed ticks every oscillator period
    base     = ds_r | div2_r;
    mc_nxt   = mc_r;
    half_nxt = half_r;
    var_nxt  = var_r;
    if (base) begin
      mc_nxt   = (mc_r == MC_LAST) ? 3'h0 : 3'(mc_r + 3'h1);
      half_nxt = ~half_r;
      var_nxt  = (var_r == reload_i) ? 8'h00 : 8'(var_r + 8'h01);
    end
    ticks_o.m0_lo   = (mc_r < M0_RISE);
    ticks_o.m0_rise = base & (mc_r == M0_RISE);
    ticks_o.m0_end  = base & (mc_r == MC_LAST);
    // mode 2: osc/64, or osc/32 with baud double; osc/32 or osc/16 in double speed
    ticks_o.ovs_fix = base & (baud_dbl_i | half_r);
    ticks_o.ovs_var = base & (var_r == reload_i);
  end

  // registers of the divider chain
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div2_r <= 1'b0;
      ds_r   <= 1'b0;
      mc_r   <= 3'h0;
      half_r <= 1'b0;
      var_r  <= 8'h00;
    end else if (ce_i) begin
      div2_r <= div2_nxt;
      ds_r   <= ds_nxt;
      mc_r   <= mc_nxt;
      half_r <= half_nxt;
      var_r  <= var_nxt;
    end
  end

endmodule // spar_baud

// ---- spar_uart.sv ----
// spar_uart: serial port with shift mode, three uart modes, framing
// check and slave address recognition, behind a wishbone slave.
// assumes: classic wishbone master on CLOCK_I; RXD_I is asynchronous.
// Operation
// - reset clears slave address and mask
// - bit 7 is framing error when checking
// - bit 7 is mode high otherwise
// - two mode bits select four modes
// - multiproc bit enables address recognition, not mode 0
// - receive enable gates reception
// - ninth tx bit sent in modes 2, 3
// - ninth rx bit stored in modes 2, 3
// - tx done at bit 8 end or stop start
// - rx done set at frame end, or at ninth bit in modes 2, 3 unless checking; software clears
// - shift clock is 12 or 6 periods
// - control register resets to zero
// - given address masks don't-care bits
// - broadcast address is address OR mask
// - command frame needs matching address
// - framing check tests stop, done at stop
//
// The implementer's own choice: register access over Wishbone.
module spar_uart (
  input  wire logic        CLOCK_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [9:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  input  wire logic        RXD_I,
  output logic             RXD_O,
  output logic             RXD_OE_N_O,
  output logic             TXD_O,
  output logic             SER_IRQ_O,
  output logic             IRQ_O
);
  import spar_pkg::*;

  // given or broadcast address match
  function automatic logic addr_match(input logic [7:0] a,
                                      input logic [7:0] sa,
                                      input logic [7:0] se);
    logic [7:0] bc;
    bc = sa | se;
    addr_match = (((a ^ sa) & se) == 8'h00)
               | (((a ^ 8'hFF) & bc) == 8'h00);
  endfunction

  // modes with a ninth data bit
  function automatic logic is_nine(input spar_mode_t m);
    is_nine = (m == MODE_UART9F) | (m == MODE_UART9V);
  endfunction

  // register file
  spar_sctl_t       sctl_r, sctl_nxt;     // serial control register
  logic             ferr_r, ferr_nxt;     // framing error flag
  spar_pctl_t       pctl_r, pctl_nxt;     // power control register
  logic [7:0]       sladr_r, sladr_nxt;   // slave address
  logic [7:0]       slmsk_r, slmsk_nxt;   // slave address mask
  logic [7:0]       baud_r, baud_nxt;     // variable rate reload
  logic [7:0]       rxbuf_r, rxbuf_nxt;   // received byte
  logic [IRQ_W-1:0] istat_r, istat_nxt;   // sticky events
  logic [IRQ_W-1:0] imask_r, imask_nxt;   // event mask
  logic             ack_r, ack_nxt;       // bus answer
  logic [31:0]      dat_r, dat_nxt;       // bus read data
  logic             irq_r, irq_nxt;       // masked interrupt
  // bus decode
  logic [7:0]       idx;                  // register index
  logic             wr_go;                // write taken this edge
  logic             wr_data;              // write to data register
  logic [7:0]       rd_val;               // read mux
  spar_mode_t       mode;                 // current port mode
  spar_ticks_t      tk;                   // divider events
  // shift mode engine
  logic             m0_busy_r, m0_busy_nxt;
  logic             m0_dir_r, m0_dir_nxt;     // 1 receive
  logic             m0_pend_r, m0_pend_nxt;   // tx waiting
  logic [2:0]       m0_cnt_r, m0_cnt_nxt;
  logic [7:0]       m0_sh_r, m0_sh_nxt;
  logic             m0_dout_r, m0_dout_nxt;
  logic             m0_oen_r, m0_oen_nxt;
  logic             m0_td_ev, m0_rd_ev;
  // uart transmitter
  spar_txst_t       tx_st_r, tx_st_nxt;
  logic [8:0]       tx_sh_r, tx_sh_nxt;
  logic [3:0]       tx_cnt_r, tx_cnt_nxt;
  logic [3:0]       tx_ovs_r, tx_ovs_nxt;
  logic             txd_r, txd_nxt;
  logic             tx_td_ev, tx_tick;
  // uart receiver
  spar_rxst_t       rx_st_r, rx_st_nxt;
  logic [8:0]       rx_sh_r, rx_sh_nxt;
  logic [3:0]       rx_cnt_r, rx_cnt_nxt;
  logic [3:0]       rx_ovs_r, rx_ovs_nxt;
  logic             rxd_s1_r, rxd_s1_nxt;     // synchroniser stage 1
  logic             rxd_s2_r, rxd_s2_nxt;     // synchroniser stage 2
  logic             rxd_old_r, rxd_old_nxt;   // edge detect
  logic             rx_done, rx_nine, rx_rd_ev, rx_ferr_ev, rx_tick;
  logic [7:0]       rx_byte;

  assign idx     = ADR_I[9:2];
  assign mode    = spar_mode_t'({sctl_r.mode_select_hi,
                                 sctl_r.mode_select_lo});
  assign wr_go   = CYC_I & STB_I & WE_I & ack_r & SEL_I[0];
  assign wr_data = wr_go & (idx == IDX_DATA);
  assign DAT_O   = dat_r;
  assign ACK_O   = ack_r;
  assign RXD_O      = m0_dout_r;
  assign RXD_OE_N_O = m0_oen_r;
  assign TXD_O      = txd_r;
  assign IRQ_O      = irq_r;
  // one request for both done flags
  assign SER_IRQ_O  = sctl_r.tx_done_flag | sctl_r.rx_done_flag;

  // baud and shift clock divider
  spar_baud u_baud (
    .clk_i      (CLOCK_I),
    .rst_i      (RST_I),
    .ce_i       (CE_I),
    .ds_i       (pctl_r.double_speed_select),
    .baud_dbl_i (pctl_r.baud_double),
    .reload_i   (baud_r),
    .ticks_o    (tk)
  );

  // register read mux
  always_comb begin
    unique case (idx)
      // bit 7 shows the error flag while checking
      IDX_SCTL:  rd_val = {pctl_r.framing_check_select ? ferr_r
                           : sctl_r.mode_select_hi, sctl_r[6:0]};
      IDX_DATA:  rd_val = rxbuf_r;
      IDX_PCTL:  rd_val = {5'h00, pctl_r};
      IDX_BAUD:  rd_val = baud_r;
      IDX_ISTAT: rd_val = {5'h00, istat_r};
      IDX_IMASK: rd_val = {5'h00, imask_r};
      IDX_SLADR: rd_val = sladr_r;
      IDX_SLMSK: rd_val = slmsk_r;
      default:   rd_val = 8'h00;  // unmapped reads zero
    endcase
  end

  // next values of the bus slave and registers
  always_comb begin
    sctl_nxt  = sctl_r;
    ferr_nxt  = ferr_r;
    pctl_nxt  = pctl_r;
    sladr_nxt = sladr_r;
    slmsk_nxt = slmsk_r;
    baud_nxt  = baud_r;
    rxbuf_nxt = rxbuf_r;
    imask_nxt = imask_r;
    istat_nxt = istat_r;
    dat_nxt   = dat_r;
    // one wait state, dropped after one cycle
    ack_nxt   = CYC_I & STB_I & ~ack_r;
    if (CYC_I & STB_I & ~ack_r & ~WE_I) begin
      dat_nxt = {24'h000000, rd_val};
    end
    if (wr_go) begin
      unique case (idx)
        IDX_SCTL: begin
          sctl_nxt = spar_sctl_t'(DAT_I[7:0]);
          if (pctl_r.framing_check_select) begin
            // software may only clear the error
            sctl_nxt.mode_select_hi = sctl_r.mode_select_hi;
            ferr_nxt = ferr_r & DAT_I[7];
          end
        end
        IDX_PCTL:  pctl_nxt  = spar_pctl_t'(DAT_I[2:0]);
        IDX_BAUD:  baud_nxt  = DAT_I[7:0];
        IDX_ISTAT: istat_nxt = istat_r & ~DAT_I[IRQ_W-1:0];
        IDX_IMASK: imask_nxt = DAT_I[IRQ_W-1:0];
        IDX_SLADR: sladr_nxt = DAT_I[7:0];
        IDX_SLMSK: slmsk_nxt = DAT_I[7:0];
        default: ;  // data and unmapped writes store nothing here
      endcase
    end
    // hardware sets win over a clear in the same cycle
    if (m0_td_ev | tx_td_ev) begin
      sctl_nxt.tx_done_flag = 1'b1;
    end
    if (m0_rd_ev) begin
      sctl_nxt.rx_done_flag = 1'b1;
      rxbuf_nxt = m0_sh_nxt;                         // ninth bit unused
    end
    if (rx_rd_ev) begin
      sctl_nxt.rx_done_flag = 1'b1;
      sctl_nxt.rx_ninth_bit = rx_nine;
      rxbuf_nxt = rx_byte;
    end
    if (rx_ferr_ev) begin
      ferr_nxt = 1'b1;
    end
    istat_nxt[IRQ_TX]   = istat_nxt[IRQ_TX] | m0_td_ev | tx_td_ev;
    istat_nxt[IRQ_RX]   = istat_nxt[IRQ_RX] | m0_rd_ev | rx_rd_ev;
    istat_nxt[IRQ_FERR] = istat_nxt[IRQ_FERR] | rx_ferr_ev;
    irq_nxt = |(istat_nxt & imask_nxt);
  end

  // next values of the shift register mode engine
  always_comb begin
    m0_busy_nxt = m0_busy_r;
    m0_dir_nxt  = m0_dir_r;
    m0_pend_nxt = m0_pend_r;
    m0_cnt_nxt  = m0_cnt_r;
    m0_sh_nxt   = m0_sh_r;
    m0_td_ev    = 1'b0;
    m0_rd_ev    = 1'b0;
    if (!m0_busy_r) begin
      if (wr_data && mode == MODE_SHIFT) begin
        m0_pend_nxt = 1'b1;
        m0_sh_nxt   = DAT_I[7:0];
      end
      // frames start on a shift bit boundary
      if (tk.m0_end && mode == MODE_SHIFT) begin
        if (m0_pend_r) begin
          m0_busy_nxt = 1'b1;
          m0_dir_nxt  = 1'b0;
          m0_pend_nxt = 1'b0;
          m0_cnt_nxt  = 3'h0;
        end else if (sctl_r.rx_enable && !sctl_r.rx_done_flag) begin
          m0_busy_nxt = 1'b1;
          m0_dir_nxt  = 1'b1;
          m0_cnt_nxt  = 3'h0;
        end
      end
    end else begin
      // sample on the rising shift clock
      if (tk.m0_rise && m0_dir_r) begin
        m0_sh_nxt = {rxd_s2_r, m0_sh_r[7:1]};
      end
      if (tk.m0_end) begin
        if (!m0_dir_r) begin
          m0_sh_nxt = {1'b0, m0_sh_r[7:1]};
        end
        m0_cnt_nxt = 3'(m0_cnt_r + 3'h1);
        if (m0_cnt_r == 3'h7) begin
          // end of the eighth bit time
          m0_busy_nxt = 1'b0;
          m0_td_ev    = ~m0_dir_r;
          m0_rd_ev    = m0_dir_r;
        end
      end
    end
    // drive the data pin only while transmitting
    m0_oen_nxt  = ~(m0_busy_nxt & ~m0_dir_nxt);
    m0_dout_nxt = m0_oen_nxt | m0_sh_nxt[0];
  end

  // next values of the uart transmitter
  always_comb begin
    tx_st_nxt  = tx_st_r;
    tx_sh_nxt  = tx_sh_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_ovs_nxt = tx_ovs_r;
    tx_td_ev   = 1'b0;
    tx_tick    = (mode == MODE_UART9F) ? tk.ovs_fix : tk.ovs_var;
    unique case (tx_st_r)
      TX_IDLE: begin
        if (wr_data && mode != MODE_SHIFT) begin
          tx_sh_nxt  = {sctl_r.tx_ninth_bit, DAT_I[7:0]};
          tx_st_nxt  = TX_START;
          tx_ovs_nxt = 4'h0;
          tx_cnt_nxt = 4'h0;
        end
      end
      TX_START: begin
        if (tx_tick) begin
          tx_ovs_nxt = 4'(tx_ovs_r + 4'h1);
          if (tx_ovs_r == OVS_LAST) begin
            tx_st_nxt = TX_DATA;
          end
        end
      end
      TX_DATA: begin
        if (tx_tick) begin
          tx_ovs_nxt = 4'(tx_ovs_r + 4'h1);
          if (tx_ovs_r == OVS_LAST) begin
            tx_sh_nxt  = {1'b1, tx_sh_r[8:1]};
            tx_cnt_nxt = 4'(tx_cnt_r + 4'h1);
            // eight bits, or nine in modes 2 and 3
            if (tx_cnt_r == (is_nine(mode) ? LAST_BIT9 : LAST_BIT8)) begin
              tx_st_nxt = TX_STOP;
              tx_td_ev  = 1'b1;
            end
          end
        end
      end
      TX_STOP: begin
        if (tx_tick) begin
          tx_ovs_nxt = 4'(tx_ovs_r + 4'h1);
          if (tx_ovs_r == OVS_LAST) begin
            tx_st_nxt = TX_IDLE;
          end
        end
      end
    endcase
    // shift clock in mode 0, serial data otherwise
    if (mode == MODE_SHIFT) begin
      txd_nxt = ~(m0_busy_r & tk.m0_lo);
    end else begin
      txd_nxt = (tx_st_nxt == TX_START) ? 1'b0
              : (tx_st_nxt == TX_DATA)  ? tx_sh_nxt[0] : 1'b1;
    end
  end

  // next values of the uart receiver
  always_comb begin
    rxd_s1_nxt  = RXD_I;
    rxd_s2_nxt  = rxd_s1_r;
    rxd_old_nxt = rxd_s2_r;
    rx_st_nxt   = rx_st_r;
    rx_sh_nxt   = rx_sh_r;
    rx_cnt_nxt  = rx_cnt_r;
    rx_ovs_nxt  = rx_ovs_r;
    rx_done     = 1'b0;
    rx_nine     = 1'b0;
    rx_ferr_ev  = 1'b0;
    rx_tick     = (mode == MODE_UART9F) ? tk.ovs_fix : tk.ovs_var;
    unique case (rx_st_r)
      RX_IDLE: begin
        // start bit edge, only while enabled
        if (sctl_r.rx_enable && mode != MODE_SHIFT &&
            rxd_old_r && !rxd_s2_r) begin
          rx_st_nxt  = RX_START;
          rx_ovs_nxt = 4'h0;
        end
      end
      RX_START: begin
        if (rx_tick) begin
          rx_ovs_nxt = 4'(rx_ovs_r + 4'h1);
          if (rx_ovs_r == OVS_MID) begin
            // a high line at mid start bit is a glitch
            rx_st_nxt  = rxd_s2_r ? RX_IDLE : RX_DATA;
            rx_ovs_nxt = 4'h0;
            rx_cnt_nxt = 4'h0;
          end
        end
      end
      RX_DATA: begin
        if (rx_tick) begin
          rx_ovs_nxt = 4'(rx_ovs_r + 4'h1);
          if (rx_ovs_r == OVS_LAST) begin
            rx_sh_nxt  = {rxd_s2_r, rx_sh_r[8:1]};
            rx_cnt_nxt = 4'(rx_cnt_r + 4'h1);
            if (rx_cnt_r == (is_nine(mode) ? LAST_BIT9 : LAST_BIT8)) begin
              rx_st_nxt = RX_STOP;
              // in modes 2 and 3, done at the last data bit unless checking
              rx_done = is_nine(mode) & ~pctl_r.framing_check_select;
              rx_nine = rxd_s2_r;
            end
          end
        end
      end
      RX_STOP: begin
        if (rx_tick) begin
          rx_ovs_nxt = 4'(rx_ovs_r + 4'h1);
          if (rx_ovs_r == OVS_LAST) begin
            rx_st_nxt = RX_IDLE;
            rx_ferr_ev = pctl_r.framing_check_select & ~rxd_s2_r;
            rx_done   = ~is_nine(mode) | pctl_r.framing_check_select;
            // mode 1 takes the stop bit in the ninth place
            rx_nine   = is_nine(mode) ? rx_sh_r[8] : rxd_s2_r;
          end
        end
      end
    endcase
    rx_byte = is_nine(mode) ? rx_sh_nxt[7:0] : rx_sh_nxt[8:1];
    // command frames must carry our address
    rx_rd_ev = rx_done & ~sctl_r.rx_done_flag &
               (~sctl_r.multiproc_enable |
                (rx_nine & addr_match(rx_byte, sladr_r, slmsk_r)));
  end

  // all state registers; reset clears the control registers
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      sctl_r    <= spar_sctl_t'(SCTL_RST);
      ferr_r    <= 1'b0;
      pctl_r    <= spar_pctl_t'(PCTL_RST);
      sladr_r   <= SLADR_RST;
      slmsk_r   <= SLMSK_RST;
      baud_r    <= BAUD_RST;
      rxbuf_r   <= 8'h00;
      istat_r   <= 3'h0;
      imask_r   <= IMASK_RST;
      ack_r     <= 1'b0;
      dat_r     <= 32'h00000000;
      irq_r     <= 1'b0;
      m0_busy_r <= 1'b0;
      m0_dir_r  <= 1'b0;
      m0_pend_r <= 1'b0;
      m0_cnt_r  <= 3'h0;
      m0_sh_r   <= 8'h00;
      m0_dout_r <= 1'b1;
      m0_oen_r  <= 1'b1;
      tx_st_r   <= TX_IDLE;
      tx_sh_r   <= 9'h000;
      tx_cnt_r  <= 4'h0;
      tx_ovs_r  <= 4'h0;
      txd_r     <= 1'b1;
      rx_st_r   <= RX_IDLE;
      rx_sh_r   <= 9'h000;
      rx_cnt_r  <= 4'h0;
      rx_ovs_r  <= 4'h0;
      rxd_s1_r  <= 1'b1;
      rxd_s2_r  <= 1'b1;
      rxd_old_r <= 1'b1;
    end else if (CE_I) begin
      sctl_r    <= sctl_nxt;
      ferr_r    <= ferr_nxt;
      pctl_r    <= pctl_nxt;
      sladr_r   <= sladr_nxt;
      slmsk_r   <= slmsk_nxt;
      baud_r    <= baud_nxt;
      rxbuf_r   <= rxbuf_nxt;
      istat_r   <= istat_nxt;
      imask_r   <= imask_nxt;
      ack_r     <= ack_nxt;
      dat_r     <= dat_nxt;
      irq_r     <= irq_nxt;
      m0_busy_r <= m0_busy_nxt;
      m0_dir_r  <= m0_dir_nxt;
      m0_pend_r <= m0_pend_nxt;
      m0_cnt_r  <= m0_cnt_nxt;
      m0_sh_r   <= m0_sh_nxt;
      m0_dout_r <= m0_dout_nxt;
      m0_oen_r  <= m0_oen_nxt;
      tx_st_r   <= tx_st_nxt;
      tx_sh_r   <= tx_sh_nxt;
      tx_cnt_r  <= tx_cnt_nxt;
      tx_ovs_r  <= tx_ovs_nxt;
      txd_r     <= txd_nxt;
      rx_st_r   <= rx_st_nxt;
      rx_sh_r   <= rx_sh_nxt;
      rx_cnt_r  <= rx_cnt_nxt;
      rx_ovs_r  <= rx_ovs_nxt;
      rxd_s1_r  <= rxd_s1_nxt;
      rxd_s2_r  <= rxd_s2_nxt;
      rxd_old_r <= rxd_old_nxt;
    end
  end

endmodule // spar_uart

// ---- spar_uart_monitor.sv ----
// spar_uart_monitor: port-level checks of the serial port top.
// assumes: bound into spar_uart, one clock domain, CE_I held high.
module spar_uart_monitor (
  input wire logic        CLOCK_I,
  input wire logic        RST_I,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [9:0]  ADR_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  input wire logic        RXD_O,
  input wire logic        RXD_OE_N_O,
  input wire logic        SER_IRQ_O,
  input wire logic        IRQ_O
);
  import spar_pkg::*;
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);
  // a taken request is answered on the next edge, for one cycle only
  a_ack_next_cycle: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("request not answered in one cycle");
  a_ack_single_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  a_rdata_byte_wide: assert property (ACK_O |-> DAT_O[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  a_rdata_held: assert property ($changed(DAT_O) |-> ACK_O && !WE_I)
    else $error("read data moved outside a read");
  a_pin_idle_high: assert property (RXD_OE_N_O |-> RXD_O)
    else $error("released data pin not high");
  // done flags fall only through a register write
  a_done_sw_clear: assert property ($fell(SER_IRQ_O) |-> $past(ACK_O && WE_I))
    else $error("done flag fell without a write");
  a_reset_quiet: assert property ($past(RST_I) |-> !SER_IRQ_O && !IRQ_O && !ACK_O)
    else $error("outputs not quiet after reset");
  a_mask_silences: assert property (ACK_O && WE_I && ADR_I[9:2] == IDX_IMASK
    && DAT_I[2:0] == 3'h0 |=> ##1 !IRQ_O)
    else $error("interrupt high with mask cleared");
  a_irq_sticky: assert property ($fell(IRQ_O) |-> $past(ACK_O && WE_I)
    || $past(ACK_O && WE_I, 2))
    else $error("interrupt fell without a write");
endmodule  // spar_uart_monitor

bind spar_uart spar_uart_monitor spar_uart_monitor_i (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
  .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
  .ACK_O(ACK_O), .RXD_O(RXD_O), .RXD_OE_N_O(RXD_OE_N_O), .SER_IRQ_O(SER_IRQ_O),
  .IRQ_O(IRQ_O));

// ---- spar_peer.sv ----
// spar_peer: remote serial port sending uart frames into the receiver.
// assumes: the bench gives the bit period in clocks to match the port.
module spar_peer (
  input  wire logic CLOCK_I,
  output logic      rxd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxd_o = 1'b1;  // line idles at mark
  // start, data lsb first, ninth bit set on address frames, stop
  task automatic send(input logic [8:0] d, input bit nine, input logic stp, input int t);
    logic [10:0] f;
    f = nine ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(posedge CLOCK_I);
      rxd_o <= f[i];
      repeat (t - 1) @(posedge CLOCK_I);
    end
    @(posedge CLOCK_I);
    rxd_o <= 1'b1;  // back to idle after a broken stop
  endtask
endmodule  // spar_peer

// ---- test_spar_uart.sv ----
// test_spar_uart: self-checking bench for the serial port top.
// assumes: baud reload 0 and standard speed, so one uart bit is 32 clocks.
module test_spar_uart;
  timeunit 1ns;
  timeprecision 1ns;
  import spar_pkg::*;
  localparam int BIT_T = 2 * 16;  // two clocks per tick, 16 ticks per bit
  logic        clk, rst, cyc, stb, we, rxd, ack, ser_irq, irq, acc, txd;
  logic [9:0]  adr;
  logic [31:0] wdat, rdat;
  logic [7:0]  q, sa, se, a;
  integer      n_fail = 0;
  integer      checks = 0;
  integer      seed   = 32'hf112cb98;
  int          t, p;
  spar_uart spar_uart_i (.CLOCK_I(clk), .RST_I(rst), .CE_I(1'b1), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(wdat), .DAT_O(rdat),
    .ACK_O(ack), .RXD_I(rxd), .RXD_O(), .RXD_OE_N_O(), .TXD_O(txd), .SER_IRQ_O(ser_irq),
    .IRQ_O(irq));
  spar_peer spar_peer_i (.CLOCK_I(clk), .rxd_o(rxd));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle, held until ack is seen high
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) n_fail++;
  endtask
  task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(nm, q, exp);
  endtask
  // given address with masked bits free, or broadcast address
  function automatic logic hit(input logic [7:0] x, s, m);
    return (((x ^ s) & m) == 8'h00) || (((x ^ (s | m)) & (s | m)) == 8'h00);
  endfunction
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {cyc, stb, we, adr, wdat, rst} = '0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd("control", IDX_SCTL, SCTL_RST);
    rd("slave_address", IDX_SLADR, SLADR_RST);
    rd("address_mask", IDX_SLMSK, SLMSK_RST);
    rd("unmapped", 8'h3F, 8'h00);
    $display("reset test done");
    sa = 8'($random(seed));
    se = 8'($random(seed)) | 8'h01;
    bus(1'b1, IDX_SLADR, sa);
    bus(1'b1, IDX_SLMSK, se);
    rd("slave_address", IDX_SLADR, sa);
    bus(1'b1, IDX_SCTL, 8'hF0);
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? sa : (i == 1) ? (sa | se) : (i == 2) ? ~sa : 8'($random(seed));
      acc = hit(a, sa, se);
      spar_peer_i.send({1'b1, a}, 1'b1, 1'b1, BIT_T);
      chk("serial_irq", {7'h0, ser_irq}, {7'h0, acc});
      rd("rx_done", IDX_SCTL, 8'hF0 | {5'h0, acc, 1'b0, acc});
      if (acc) rd("rx_data", IDX_DATA, a);
      bus(1'b1, IDX_SCTL, 8'hF0);
    end
    $display("address test done");
    bus(1'b1, IDX_SCTL, 8'h40);
    spar_peer_i.send(9'h055, 1'b0, 1'b1, BIT_T);
    rd("rx_disabled", IDX_SCTL, 8'h40);
    bus(1'b1, IDX_SCTL, 8'h50);
    bus(1'b1, IDX_PCTL, 8'h01);
    bus(1'b1, IDX_IMASK, 8'h04);
    spar_peer_i.send(9'h0A5, 1'b0, 1'b0, BIT_T);
    bus(1'b0, IDX_SCTL, 8'h00);
    chk("framing_error", q & 8'hF2, 8'hD0);
    chk("irq_set", {7'h0, irq}, 8'h01);
    bus(1'b1, IDX_IMASK, 8'h00);
    @(posedge clk);
    chk("irq_masked", {7'h0, irq}, 8'h00);
    bus(1'b1, IDX_IMASK, 8'h04);
    bus(1'b1, IDX_ISTAT, 8'h04);
    repeat (3) @(posedge clk);
    chk("irq_clear", {7'h0, irq}, 8'h00);
    bus(1'b1, IDX_SCTL, 8'h50);
    bus(1'b0, IDX_SCTL, 8'h00);
    chk("ferr_clear", q & 8'hF2, 8'h50);
    bus(1'b1, IDX_PCTL, 8'h00);
    bus(1'b1, IDX_SCTL, 8'h80);
    rd("mode_hi", IDX_SCTL, 8'h80);
    $display("framing test done");
    bus(1'b1, IDX_SCTL, 8'h40);
    bus(1'b1, IDX_DATA, 8'hA5);
    for (int i = 0; i < 8; i++) begin
      repeat (i ? BIT_T : BIT_T + BIT_T / 2) @(posedge clk);
      q[i] = txd;
    end
    chk("tx_line", q, 8'hA5);
    for (int n = 0; n < 600 && ser_irq !== 1'b1; n++) @(posedge clk);
    rd("tx_done", IDX_SCTL, 8'h42);
    $display("transmit test done");
    for (int x = 0; x < 2; x++) begin
      bus(1'b1, IDX_PCTL, {6'h0, x[0], 1'b0});
      bus(1'b1, IDX_SCTL, 8'h00);
      bus(1'b1, IDX_DATA, 8'h3C);
      for (t = 0; t < 200 && ser_irq !== 1'b1; t++) @(posedge clk);
      p = SHIFT_T_STD >> x;
      chk("m0_time", {7'h0, t >= 8 * p + 2 && t <= 9 * p + 1}, 8'h01);
    end
    $display("shift test done");
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
endmodule  // test_spar_uart
